// ---- hdl/pcr_config_regs.sv ----
// pcr_config_regs: pcs configuration and reduced-mii bypass registers with rx path
// assumes avalon-mm master on clk_sys_in, ref_tick_in a 50 MHz strobe in this domain
//
// Contract
// - signal detect select resets 1: enhanced algorithm; 0 selects reduced one
// - descrambler timeout bit resets 0 for 722 us; 1 gives 2 ms
// - forced good link bit 1 reports good 100 Mbps link; resets 0
// - nrzi bypass bit 1 skips nrzi coding on 100 Mbps path; resets 0
// - reduced-mii register bits 15 to 6 read zero, writes ignored
// - reduced-mii mode resets from strap, writable; 1 reduced, 0 standard mii
// - with reduced mode off, all its logic is bypassed and mii passes through
// - revision bit 0 (reset): crs_dv toggles at packet end after carrier drops
// - revision bit 1: crs_dv held until last data, no toggling
// - overflow flag read-only, set on fifo overflow, resets 0
// - underflow flag read-only, set on fifo underflow, resets 0
// - depth field resets 01; codes give 14, 2, 6, 10 bit tolerance
// - elasticity buffer absorbs 50 MHz reference versus recovered clock drift
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/100ps
module pcr_config_regs
  import pcr_pkg::*;
#(
  parameter logic [TMR_W-1:0] DESC_SHORT_CYCLES = TMR_W'(DESC_SHORT_CYC),
  parameter logic [TMR_W-1:0] DESC_LONG_CYCLES  = TMR_W'(DESC_LONG_CYC)
) (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // interrupt
  output logic             irq_out,
  // strap pin
  input  wire logic        strap_rmii_mode_in,
  // 100 Mbps pcs side
  input  wire logic        link_ok_100_in,
  input  wire logic        descr_locked_in,
  input  wire logic        descr_idle_in,
  output logic             signal_detect_select_out,
  output logic             descrambler_timeout_long_out,
  output logic             nrzi_bypass_out,
  output logic             link_good_100_out,
  output logic             descr_timeout_out,
  // receive stream from the recovered clock side
  input  wire logic        rx_sym_valid_in,
  input  wire logic [1:0]  rx_sym_in,
  input  wire logic        rx_carrier_in,
  input  wire logic        ref_tick_in,
  // plain mii receive
  input  wire logic [3:0]  mii_rxd_in,
  input  wire logic        mii_rx_dv_in,
  input  wire logic        mii_crs_in,
  // mac side
  output logic      [3:0]  mac_rxd_out,
  output logic             mac_rx_dv_out,
  output logic             mac_crs_out
);
  // bus and register state
  pcr_pcs_cfg_s     pcs_q, pcs_d;
  pcr_rmii_cfg_s    rmii_q, rmii_d;
  logic [IRQ_W-1:0] sts_q, sts_d, en_q, en_d, events;
  logic             ack_q, ack_d;
  logic [31:0]      rdata_q, rdata_d;
  logic [1:0]       strap_cnt_q, strap_cnt_d;
  logic             strap_sync;
  logic             req, wr_go;
  logic [5:0]       idx;
  logic [15:0]      word, wmask, wdat;
  // descrambler timer
  logic [TMR_W-1:0] tmr_q, tmr_d, tmr_lim;
  logic             dto_q, dto_d;
  // receive path
  pcr_rx_state_e    st_q, st_d;
  logic             tog_q, tog_d;
  logic [3:0]       rxd_q, rxd_d;
  logic             dv_q, dv_d, crs_q, crs_d;
  logic             flush, pop, push, fifo_empty;
  logic [1:0]       fifo_data;
  logic [FIFO_AW:0] fifo_cnt;
  logic             fifo_ovf, fifo_unf;

  pcr_sync2 u_strap_sync (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .async_in   (strap_rmii_mode_in),
    .sync_out   (strap_sync)
  );

  pcr_elastic_fifo u_fifo (
    .clk_sys_in    (clk_sys_in),
    .rstn_in       (rstn_in),
    .flush_in      (flush),
    .wr_valid_in   (push),
    .wr_data_in    (rx_sym_in),
    .rd_en_in      (pop),
    .rd_data_out   (fifo_data),
    .count_out     (fifo_cnt),
    .overflow_out  (fifo_ovf),
    .underflow_out (fifo_unf)
  );

  // register bus: one wait cycle, then the answer
  always_comb begin
    req   = avs_read_in || avs_write_in;
    ack_d = req && !ack_q;
    wr_go = avs_write_in && ack_q;
    idx   = avs_address_in[7:2];
    wmask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    wdat  = avs_writedata_in[15:0];
    avs_waitrequest_out = req && !ack_q;

    word = '0;
    case (idx)
      IDX_PCS: begin
        word[PCS_SD_BIT]    = pcs_q.sd_enhanced;
        word[PCS_DESC_BIT]  = pcs_q.desc_long;
        word[PCS_FORCE_BIT] = pcs_q.force_good;
        word[PCS_NRZI_BIT]  = pcs_q.nrzi_bypass;
      end
      IDX_RBR: begin
        word[RBR_MODE_BIT] = rmii_q.rmii_on;
        word[RBR_REV_BIT]  = rmii_q.old_rev;
        word[RBR_OVF_BIT]  = sts_q[IRQ_OVF];
        word[RBR_UNF_BIT]  = sts_q[IRQ_UNF];
        word[RBR_DEPTH_LSB+:2] = rmii_q.depth;
      end
      IDX_IRQ_STS: word[IRQ_W-1:0] = sts_q;
      IDX_IRQ_EN:  word[IRQ_W-1:0] = en_q;
      default:     word = '0;
    endcase
    rdata_d = (avs_read_in && ack_d) ? {16'h0, word} : rdata_q;

    pcs_d  = pcs_q;
    rmii_d = rmii_q;
    en_d   = en_q;
    // reserved bits are not stored, so a nonzero write leaves no trace
    if (wr_go && idx == IDX_PCS) begin
      if (wmask[PCS_SD_BIT]) begin
        pcs_d.sd_enhanced = wdat[PCS_SD_BIT];
      end
      if (wmask[PCS_DESC_BIT]) begin
        pcs_d.desc_long = wdat[PCS_DESC_BIT];
      end
      if (wmask[PCS_FORCE_BIT]) begin
        pcs_d.force_good = wdat[PCS_FORCE_BIT];
      end
      if (wmask[PCS_NRZI_BIT]) begin
        pcs_d.nrzi_bypass = wdat[PCS_NRZI_BIT];
      end
    end
    // flag bits and bits 15:6 have no write path
    if (wr_go && idx == IDX_RBR && wmask[0]) begin
      rmii_d.rmii_on = wdat[RBR_MODE_BIT];
      rmii_d.old_rev = wdat[RBR_REV_BIT];
      rmii_d.depth   = wdat[RBR_DEPTH_LSB+:2];
    end
    // strap caught once, after the synchroniser has settled
    strap_cnt_d = strap_cnt_q;
    if (strap_cnt_q != STRAP_WAIT) begin
      strap_cnt_d = strap_cnt_q + 2'h1;
      if (strap_cnt_d == STRAP_WAIT) begin
        rmii_d.rmii_on = strap_sync;
      end
    end
    if (wr_go && idx == IDX_IRQ_EN && wmask[0]) begin
      en_d = wdat[IRQ_W-1:0];
    end

    events          = '0;
    events[IRQ_OVF] = fifo_ovf;
    events[IRQ_UNF] = fifo_unf;
    events[IRQ_DSC] = dto_q;
    sts_d = sts_q;
    if (wr_go && idx == IDX_IRQ_CLR && wmask[0]) begin
      sts_d = sts_q & ~wdat[IRQ_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    sts_d = sts_d | events;
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pcs_q       <= '{sd_enhanced: SD_RST, desc_long: DESC_RST,
                       force_good: FORCE_RST, nrzi_bypass: NRZI_RST};
      rmii_q      <= '{rmii_on: 1'h0, old_rev: REV_RST, depth: DEPTH_RST};
      sts_q       <= '0;
      en_q        <= '0;
      ack_q       <= 1'h0;
      rdata_q     <= '0;
      strap_cnt_q <= '0;
    end else begin
      pcs_q       <= pcs_d;
      rmii_q      <= rmii_d;
      sts_q       <= sts_d;
      en_q        <= en_d;
      ack_q       <= ack_d;
      rdata_q     <= rdata_d;
      strap_cnt_q <= strap_cnt_d;
    end
  end

  // descrambler timeout: restarted by every idle seen while locked
  always_comb begin
    tmr_lim = pcs_q.desc_long ? DESC_LONG_CYCLES : DESC_SHORT_CYCLES;
    dto_d   = 1'h0;
    tmr_d   = tmr_q + TMR_W'(1);
    if (!descr_locked_in || descr_idle_in) begin
      tmr_d = '0;
    end else if (tmr_q >= tmr_lim - TMR_W'(1)) begin
      tmr_d = '0;
      dto_d = 1'h1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tmr_q <= '0;
      dto_q <= 1'h0;
    end else begin
      tmr_q <= tmr_d;
      dto_q <= dto_d;
    end
  end

  // receive path: prefill, stream, drain on 50 MHz ticks
  always_comb begin
    fifo_empty = (fifo_cnt == '0);
    st_d  = st_q;
    tog_d = tog_q;
    flush = 1'h0;
    pop   = 1'h0;
    push  = rmii_q.rmii_on && st_q != ST_IDLE && rx_sym_valid_in;
    rxd_d = rxd_q;
    dv_d  = dv_q;
    crs_d = 1'h0;
    case (st_q)
      ST_IDLE: begin
        flush = 1'h1;
        rxd_d = '0;
        dv_d  = 1'h0;
        if (rx_carrier_in) begin
          st_d = ST_PREFILL;
          dv_d = 1'h1;
        end
      end
      ST_PREFILL: begin
        // hold data at zero until enough slack is stored
        if (ref_tick_in && fifo_cnt >= pcr_prefill(rmii_q.depth)) begin
          st_d = ST_STREAM;
        end
      end
      ST_STREAM: begin
        if (ref_tick_in) begin
          pop   = !fifo_empty || rx_carrier_in;
          rxd_d = {2'h0, fifo_empty ? 2'h0 : fifo_data};
          if (!rx_carrier_in) begin
            st_d  = ST_DRAIN;
            tog_d = 1'h0;
          end
        end
      end
      ST_DRAIN: begin
        if (ref_tick_in) begin
          if (fifo_empty) begin
            st_d  = ST_IDLE;
            rxd_d = '0;
            dv_d  = 1'h0;
          end else begin
            pop   = 1'h1;
            rxd_d = {2'h0, fifo_data};
            dv_d  = rmii_q.old_rev || tog_q;
            tog_d = !tog_q;
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // switching the mode off drops any frame in flight
    if (!rmii_q.rmii_on) begin
      st_d  = ST_IDLE;
      pop   = 1'h0;
      rxd_d = mii_rxd_in;
      dv_d  = mii_rx_dv_in;
      crs_d = mii_crs_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q  <= ST_IDLE;
      tog_q <= 1'h0;
      rxd_q <= '0;
      dv_q  <= 1'h0;
      crs_q <= 1'h0;
    end else begin
      st_q  <= st_d;
      tog_q <= tog_d;
      rxd_q <= rxd_d;
      dv_q  <= dv_d;
      crs_q <= crs_d;
    end
  end

  assign avs_readdata_out             = rdata_q;
  assign irq_out                      = |(sts_q & en_q);
  assign signal_detect_select_out     = pcs_q.sd_enhanced;
  assign descrambler_timeout_long_out = pcs_q.desc_long;
  assign nrzi_bypass_out              = pcs_q.nrzi_bypass;
  assign link_good_100_out            = pcs_q.force_good || link_ok_100_in;
  assign descr_timeout_out            = dto_q;
  assign mac_rxd_out                  = rxd_q;
  assign mac_rx_dv_out                = dv_q;
  assign mac_crs_out                  = crs_q;
endmodule : pcr_config_regs

// ---- hdl/pcr_pkg.sv ----
// pcr_pkg: constants, register map and carrier types of the pcs/rmii config block
// assumes a 100 MHz system clock and a 32-bit avalon-mm register bus
package pcr_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned DESC_SHORT_NS = 722000;
  localparam int unsigned DESC_LONG_NS  = 2000000;
  // a timeout is a longest time: round down
  localparam int unsigned DESC_SHORT_CYC = DESC_SHORT_NS / CLK_PERIOD_NS;
  localparam int unsigned DESC_LONG_CYC  = DESC_LONG_NS / CLK_PERIOD_NS;
  localparam int unsigned TMR_W          = 21;

  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_PCS     = 6'h16;
  localparam logic [5:0] IDX_RBR     = 6'h17;
  localparam logic [5:0] IDX_IRQ_STS = 6'h20;
  localparam logic [5:0] IDX_IRQ_CLR = 6'h21;
  localparam logic [5:0] IDX_IRQ_EN  = 6'h22;

  // pcs_config_status fields
  localparam int unsigned PCS_SD_BIT    = 8;
  localparam int unsigned PCS_DESC_BIT  = 7;
  localparam int unsigned PCS_FORCE_BIT = 5;
  localparam int unsigned PCS_NRZI_BIT  = 2;
  // reduced_mii_bypass_ctrl fields
  localparam int unsigned RBR_MODE_BIT  = 5;
  localparam int unsigned RBR_REV_BIT   = 4;
  localparam int unsigned RBR_OVF_BIT   = 3;
  localparam int unsigned RBR_UNF_BIT   = 2;
  localparam int unsigned RBR_DEPTH_LSB = 0;

  // reset values
  localparam logic       SD_RST    = 1'h1;
  localparam logic       DESC_RST  = 1'h0;
  localparam logic       FORCE_RST = 1'h0;
  localparam logic       NRZI_RST  = 1'h0;
  localparam logic       REV_RST   = 1'h0;
  localparam logic [1:0] DEPTH_RST = 2'h1;

  // interrupt status bits
  localparam int unsigned IRQ_OVF = 0;
  localparam int unsigned IRQ_UNF = 1;
  localparam int unsigned IRQ_DSC = 2;
  localparam int unsigned IRQ_W   = 3;

  // elasticity buffer, counted in dibits
  localparam int unsigned FIFO_AW    = 4;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [1:0]  STRAP_WAIT = 2'h3;
  localparam logic [4:0]  TOL_BITS_0 = 5'he;
  localparam logic [4:0]  TOL_BITS_1 = 5'h2;
  localparam logic [4:0]  TOL_BITS_2 = 5'h6;
  localparam logic [4:0]  TOL_BITS_3 = 5'ha;

  typedef struct packed {
    logic sd_enhanced;
    logic desc_long;
    logic force_good;
    logic nrzi_bypass;
  } pcr_pcs_cfg_s;

  typedef struct packed {
    logic       rmii_on;
    logic       old_rev;
    logic [1:0] depth;
  } pcr_rmii_cfg_s;

  typedef enum logic [1:0] {ST_IDLE, ST_PREFILL, ST_STREAM, ST_DRAIN} pcr_rx_state_e;

  // dibits held before the first one is sent: half the tolerance
  function automatic logic [4:0] pcr_prefill(input logic [1:0] depth);
    logic [4:0] tol;
    case (depth)
      2'h0:    tol = TOL_BITS_0;
      2'h1:    tol = TOL_BITS_1;
      2'h2:    tol = TOL_BITS_2;
      default: tol = TOL_BITS_3;
    endcase
    return tol >> 1;
  endfunction : pcr_prefill

endpackage : pcr_pkg

// ---- hdl/pcr_sync2.sv ----
// pcr_sync2: two flip-flop synchroniser for a level from a pin
// assumes the level is slow against clk_sys_in
`timescale 1ns/100ps
module pcr_sync2 (
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rstn_in,
  // level
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q <= 1'h0;
      sync_q <= 1'h0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : pcr_sync2

// ---- hdl/pcr_elastic_fifo.sv ----
// pcr_elastic_fifo: receive elasticity buffer of dibits
// assumes writer and reader share clk_sys_in; the reader paces with its own strobe
`timescale 1ns/100ps
module pcr_elastic_fifo
  import pcr_pkg::*;
(
  // clock and reset
  input  wire logic               clk_sys_in,
  input  wire logic               rstn_in,
  // control
  input  wire logic               flush_in,
  // write side
  input  wire logic               wr_valid_in,
  input  wire logic [1:0]         wr_data_in,
  // read side
  input  wire logic               rd_en_in,
  output logic      [1:0]         rd_data_out,
  output logic      [FIFO_AW:0]   count_out,
  // errors, one-cycle pulses
  output logic                    overflow_out,
  output logic                    underflow_out
);
  logic [1:0]         mem_q [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [FIFO_AW:0]   cnt_q, cnt_d;
  logic               full, empty, wr_ok, rd_ok;

  always_comb begin
    full  = (cnt_q == (FIFO_AW+1)'(FIFO_DEPTH));
    empty = (cnt_q == '0);
    rd_ok = rd_en_in && !empty;
    // a write on full is dropped unless a read frees a slot
    wr_ok = wr_valid_in && (!full || rd_ok);
    wp_d  = flush_in ? '0 : wp_q + FIFO_AW'(wr_ok);
    rp_d  = flush_in ? '0 : rp_q + FIFO_AW'(rd_ok);
    cnt_d = flush_in ? '0 : cnt_q + (FIFO_AW+1)'(wr_ok) - (FIFO_AW+1)'(rd_ok);
    overflow_out  = !flush_in && wr_valid_in && !wr_ok;
    underflow_out = !flush_in && rd_en_in && empty;
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // storage needs no reset; nothing reads a slot before it is written
  always_ff @(posedge clk_sys_in) begin
    if (wr_ok && !flush_in) begin
      mem_q[wp_q] <= wr_data_in;
    end
  end

  assign rd_data_out = mem_q[rp_q];
  assign count_out   = cnt_q;
endmodule : pcr_elastic_fifo

// ---- test/pcr_config_regs_checker.sv ----
// pcr_config_regs_checker: port-level assertions for the pcs/rmii config block
// assumes only the top module's ports; bound in below
`timescale 1ns/100ps
module pcr_config_regs_checker (
  // clock and reset
  input wire logic        clk_sys_in,
  input wire logic        rstn_in,
  // register bus
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        irq_out,
  // pcs and mii
  input wire logic        link_ok_100_in,
  input wire logic        link_good_100_out,
  input wire logic [3:0]  mii_rxd_in,
  input wire logic        mii_rx_dv_in,
  input wire logic        mii_crs_in,
  input wire logic [3:0]  mac_rxd_out,
  input wire logic        mac_rx_dv_out,
  input wire logic        mac_crs_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  wire req  = avs_read_in | avs_write_in;
  wire done = req & !avs_waitrequest_out;

  wait_one_a: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer not after one wait state");
  wait_idle_a: assert property (!req |-> !avs_waitrequest_out)
    else $error("waitrequest without a request");
  wait_back_a: assert property (done |=> avs_waitrequest_out == req)
    else $error("second access not held for a wait state");
  rd_upper_a: assert property (avs_readdata_out[31:16] == 16'h0)
    else $error("upper read data not zero");
  link_force_a: assert property (link_ok_100_in |-> link_good_100_out)
    else $error("good link lost while link ok");
  irq_rst_a: assert property (!$past(rstn_in) |-> !irq_out)
    else $error("interrupt high straight after reset");
  crs_pass_a: assert property (mac_crs_out |-> $past(mii_crs_in))
    else $error("carrier on mac side not from mii");
  rxd_pass_a: assert property (mac_crs_out |-> mac_rxd_out == $past(mii_rxd_in))
    else $error("mii data not passed through");
  dv_pass_a: assert property (mac_crs_out |-> mac_rx_dv_out == $past(mii_rx_dv_in))
    else $error("mii data valid not passed through");

  bus_wr_c: cover property (avs_write_in && !avs_waitrequest_out);
  irq_c: cover property ($rose(irq_out));
  dv_c: cover property ($fell(mac_rx_dv_out) ##2 mac_rx_dv_out);
endmodule : pcr_config_regs_checker

bind pcr_config_regs pcr_config_regs_checker pcr_config_regs_checker_i (
  .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out),
  .link_ok_100_in(link_ok_100_in), .link_good_100_out(link_good_100_out),
  .mii_rxd_in(mii_rxd_in), .mii_rx_dv_in(mii_rx_dv_in), .mii_crs_in(mii_crs_in),
  .mac_rxd_out(mac_rxd_out), .mac_rx_dv_out(mac_rx_dv_out), .mac_crs_out(mac_crs_out));

// ---- test/pcr_mac_side_model.sv ----
// pcr_mac_side_model: recovered-clock dibit source and free-running reference ticks
// assumes the bench pulses start_in for one cycle while busy_out is low
`timescale 1ns/100ps
module pcr_mac_side_model (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rstn_in,
  // frame request
  input  wire logic       start_in,
  input  wire logic [7:0] count_in,
  input  wire logic [3:0] sym_gap_in,
  input  wire logic [3:0] tick_gap_in,
  output logic            busy_out,
  // receive stream
  output logic            rx_sym_valid_out,
  output logic [1:0]      rx_sym_out,
  output logic            rx_carrier_out,
  output logic            ref_tick_out
);
  logic [3:0] tcnt, scnt;
  logic [7:0] left;
  logic [1:0] pat;
  wire send = busy_out && left != 8'h0 && scnt == sym_gap_in - 4'h1;
  // short frames only: drift budget kept by the caller
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {tcnt, scnt, left, pat, busy_out, rx_sym_valid_out, rx_carrier_out} <= '0;
      {rx_sym_out, ref_tick_out} <= '0;
    end else begin
      tcnt <= (tcnt >= tick_gap_in - 4'h1) ? 4'h0 : tcnt + 4'h1;
      ref_tick_out <= (tcnt == 4'h0);
      rx_sym_valid_out <= send;
      // released line flips so a stale dibit never looks valid
      rx_sym_out <= send ? pat : ~rx_sym_out;
      if (start_in && !busy_out) begin
        {busy_out, rx_carrier_out, left, scnt, pat} <= {2'h3, count_in, 4'h0, 2'h1};
      end else if (busy_out) begin
        if (left == 8'h0) {busy_out, rx_carrier_out} <= 2'h0;
        else if (send) {scnt, pat, left} <= {4'h0, pat + 2'h1, left - 8'h1};
        else scnt <= scnt + 4'h1;
      end
    end
  end
endmodule : pcr_mac_side_model

// ---- test/pcr_config_regs_test.sv ----
// pcr_config_regs_test: register, timer, interrupt and receive path sequences
// assumes small timer counts and the mac side model for the receive stream
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module pcr_config_regs_test;
  import pcr_pkg::*;
  localparam logic [TMR_W-1:0] T_SHORT = 21'h14;
  localparam logic [TMR_W-1:0] T_LONG  = 21'h32;
  logic clk_sys_in = 1'b0, rstn_in, avs_read_in, avs_write_in, avs_waitrequest_out, irq_out;
  logic [7:0] avs_address_in, p_count;
  logic [31:0] avs_writedata_in, avs_readdata_out, rd;
  logic [3:0] avs_byteenable_in, mii_rxd_in, mac_rxd_out, p_sgap, p_tgap;
  logic strap_rmii_mode_in, link_ok_100_in, descr_locked_in, descr_idle_in;
  logic signal_detect_select_out, descrambler_timeout_long_out, nrzi_bypass_out;
  logic link_good_100_out, descr_timeout_out, rx_sym_valid_in, rx_carrier_in, ref_tick_in;
  logic [1:0] rx_sym_in, cap[$];
  logic mii_rx_dv_in, mii_crs_in, mac_rx_dv_out, mac_crs_out, p_start, p_busy;
  logic collect = 1'b0, tick_seen = 1'b0, dv_d = 1'b0;
  int num_errors = 0, tests_run = 0, rises, k, bad;
  wire [3:0] pcs_o = {signal_detect_select_out, descrambler_timeout_long_out,
                      nrzi_bypass_out, link_good_100_out};

  pcr_config_regs #(.DESC_SHORT_CYCLES(T_SHORT), .DESC_LONG_CYCLES(T_LONG))
    pcr_config_regs_i (.*);
  pcr_mac_side_model pcr_mac_side_model_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .start_in(p_start), .count_in(p_count), .sym_gap_in(p_sgap), .tick_gap_in(p_tgap),
    .busy_out(p_busy), .rx_sym_valid_out(rx_sym_valid_in), .rx_sym_out(rx_sym_in),
    .rx_carrier_out(rx_carrier_in), .ref_tick_out(ref_tick_in));

  always #5 clk_sys_in = ~clk_sys_in;
  // rxd is settled one edge after each reference tick
  always @(posedge clk_sys_in) begin
    if (collect && tick_seen) cap.push_back(mac_rxd_out[1:0]);
    if (collect && mac_rx_dv_out && !dv_d) rises++;
    tick_seen <= ref_tick_in;
    dv_d <= mac_rx_dv_out;
  end

  task complete_run;
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : cyc

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys_in);
      if (avs_waitrequest_out === 1'b0) break;
    end
    if (i == 50) begin num_errors++; complete_run; end
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask : bus

  task chk_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask : chk_rd

  task rst_chk;
    rstn_in <= 1'b0;
    cyc(8);
    rstn_in <= 1'b1;
    cyc(4);
    chk_rd(8'h58, 32'h100, "pcs_reset");
    chk_rd(8'h5c, 32'h21, "rbr_reset");
  endtask : rst_chk

  task period(input logic [TMR_W-1:0] e);
    int i, n;
    for (i = 0; i < 300 && descr_timeout_out !== 1'b1; i++) @(posedge clk_sys_in);
    @(posedge clk_sys_in);
    for (n = 1; n < 300 && descr_timeout_out !== 1'b1; n++) @(posedge clk_sys_in);
    `CHK("timer_period", e, TMR_W'(n))
  endtask : period

  task run_rx(input logic [31:0] reduced_mii_bypass_ctrl, input logic [7:0] n, input logic [3:0] sg, tg);
    int i, q;
    bus(1'b1, 8'h5c, reduced_mii_bypass_ctrl);
    cap.delete();
    rises = 0;
    q = 0;
    {collect, p_count, p_sgap, p_tgap, p_start} <= {1'b1, n, sg, tg, 1'b1};
    @(posedge clk_sys_in);
    p_start <= 1'b0;
    // done once the model is idle and data valid has stayed low a while
    for (i = 0; i < 600 && (p_busy !== 1'b0 || q < 8); i++) begin
      @(posedge clk_sys_in);
      q = (mac_rx_dv_out === 1'b0) ? q + 1 : 0;
    end
    collect <= 1'b0;
    if (i == 600) begin num_errors++; complete_run; end
  endtask : run_rx

  initial begin
    {avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} <= '0;
    {strap_rmii_mode_in, avs_byteenable_in} <= 5'h1f;
    {link_ok_100_in, descr_locked_in, descr_idle_in, p_start} <= 4'h0;
    {mii_rxd_in, mii_rx_dv_in, mii_crs_in, p_count, p_sgap, p_tgap} <= {6'h0, 8'h1, 8'h22};
    rst_chk;
    bus(1'b1, 8'h58, 32'h1a4);
    chk_rd(8'h58, 32'h1a4, "pcs_rw");
    `CHK("pcs_out", 4'hf, pcs_o)
    bus(1'b1, 8'h58, 32'h0);
    `CHK("pcs_clr", 4'h0, pcs_o)
    link_ok_100_in <= 1'b1;
    cyc(1);
    `CHK("link_normal", 1'b1, link_good_100_out)
    bus(1'b1, 8'h5c, 32'hffff);
    chk_rd(8'h5c, 32'h33, "rbr_ro");
    for (int d = 0; d < 4; d++) begin
      bus(1'b1, 8'h5c, 32'h20 | 32'(d));
      chk_rd(8'h5c, 32'h20 | 32'(d), "depth");
    end
    bus(1'b1, 8'h40, 32'hffff);
    chk_rd(8'h40, 32'h0, "unmapped");
    descr_locked_in <= 1'b1;
    period(T_SHORT);
    bus(1'b1, 8'h58, 32'h80);
    period(T_LONG);
    // idle seen while locked keeps restarting the timer, so no pulse
    descr_idle_in <= 1'b1;
    bus(1'b1, 8'h84, 32'h4);
    cyc(60);
    chk_rd(8'h80, 32'h0, "idle_hold");
    descr_idle_in <= 1'b0;
    period(T_LONG);
    descr_locked_in <= 1'b0;
    chk_rd(8'h80, 32'h4, "irq_sts");
    bus(1'b1, 8'h88, 32'h4);
    `CHK("irq_on", 1'b1, irq_out)
    bus(1'b1, 8'h88, 32'h0);
    `CHK("irq_masked", 1'b0, irq_out)
    bus(1'b1, 8'h88, 32'h4);
    bus(1'b1, 8'h84, 32'h4);
    `CHK("irq_cleared", 1'b0, irq_out)
    bus(1'b1, 8'h5c, 32'h0);
    for (int i = 1; i < 4; i++) begin
      {mii_rxd_in, mii_rx_dv_in, mii_crs_in} <= {4'(i), 2'h3};
      cyc(2);
      `CHK("mii_pass", {4'(i), 2'h3}, {mac_rxd_out, mac_rx_dv_out, mac_crs_out})
    end
    {mii_rxd_in, mii_rx_dv_in, mii_crs_in} <= 6'h0;
    rst_chk;
    for (int r = 0; r < 2; r++) begin
      run_rx(32'h23 | (32'(r) << 4), 8'h18, 4'h2, 4'h2);
      for (k = 0; k < cap.size() && cap[k] === 2'h0; k++) ;
      bad = 0;
      for (int j = 0; j < 24; j++) if (k + j >= cap.size() || cap[k + j] !== 2'(j + 1)) bad++;
      `CHK("rx_order", 0, bad)
      `CHK("dv_single_run", 1'(r), 1'(rises == 1))
    end
    run_rx(32'h21, 8'h28, 4'h2, 4'h8);
    bus(1'b0, 8'h5c, 32'h0);
    `CHK("overflow", 1'b1, rd[3])
    bus(1'b1, 8'h5c, 32'h21);
    bus(1'b0, 8'h5c, 32'h0);
    `CHK("overflow_ro", 1'b1, rd[3])
    bus(1'b1, 8'h84, 32'h3);
    run_rx(32'h21, 8'h6, 4'h8, 4'h2);
    bus(1'b0, 8'h5c, 32'h0);
    `CHK("underflow", 1'b1, rd[2])
    complete_run;
  end
endmodule : pcr_config_regs_test
